//--- verilog/gpc_pin_ctrl.sv
// Port 1 pin control: seven 8-bit pin control registers over AXI4-Lite.
// Assumes synchronous pin inputs and an external pad that combines
// pin_o with pin_oe_n (drive while low).
// Summary of operation
// - Bit 0 of a pin register picks direction: one is input, zero is output.
// - Bit 1 inverts the pin value in both directions when set.
// - Bit 2 drives the pin from alt_drive instead of gpio_out and feeds its game port signal; gpio_in still follows the pin.
// - Bit 7 makes the output open drain when set, push-pull when clear.
// - Every pin register resets to 0x01: plain, uninverted, push-pull input.
// - Pins 1.0 and 1.1 carry stick one buttons one and two as alternate.
// - Pins 1.2 and 1.3 carry stick two buttons one and two as alternate.
// - Pins 1.4 and 1.5 carry stick one X and Y RC timing as alternate.
// - Pin 1.6 carries stick two X RC timing as alternate.
`timescale 1ns/100ps
`default_nettype none
`include "gpc_defs.svh"

module gpc_pin_ctrl
	import gpc_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [7:0]            araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic [`GPC_NPINS-1:0] pin_i,
	output logic [`GPC_NPINS-1:0]      pin_o,
	output logic [`GPC_NPINS-1:0]      pin_oe_n,
	input  wire logic [`GPC_NPINS-1:0] gpio_out,
	output logic [`GPC_NPINS-1:0]      gpio_in,
	input  wire logic [`GPC_NPINS-1:0] alt_drive,
	output logic                       stick_one_button_one,
	output logic                       stick_one_button_two,
	output logic                       stick_two_button_one,
	output logic                       stick_two_button_two,
	output logic                       stick_one_x_axis_rc,
	output logic                       stick_one_y_axis_rc,
	output logic                       stick_two_x_axis_rc
);

	gpc_state_t s;
	gpc_state_t next_s;
	logic [3:0] sel_w;
	logic [3:0] sel_r;

	// Returns {hit, pin index}; address bits 1:0 are ignored, so unaligned addresses hit too
	function automatic logic [3:0] reg_sel(input logic [7:0] a);
		logic [5:0] off;
		off = a[7:2] - `GPC_IDX_PIN0;
		if (a[7:2] >= `GPC_IDX_PIN0 && a[7:2] <= `GPC_IDX_PIN6)
			return {1'b1, off[2:0]};
		return 4'h0;
	endfunction

	assign sel_w = reg_sel(s.waddr);
	assign sel_r = reg_sel(araddr);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [7:0] c;
		logic       drv;
		logic       inb;
		c = 8'h00;
		drv = 1'b0;
		inb = 1'b0;
		next_s = s;
		// Address and data may arrive in either order
		if (s.awready && awvalid) begin
			next_s.aw_got = 1'b1;
			next_s.waddr = awaddr;
		end
		if (s.wready && wvalid) begin
			next_s.w_got = 1'b1;
			next_s.wdata = wdata[7:0];
			next_s.wstb = wstrb[0];
		end
		case (s.wst)
			GPC_WR_IDLE: begin
				if (s.aw_got && s.w_got) begin
					if (sel_w[3] && s.wstb)
						next_s.cfg[sel_w[2:0]] = s.wdata & `GPC_WMASK;
					next_s.bresp = sel_w[3] ? `GPC_RESP_OKAY : `GPC_RESP_SLV;
					next_s.bvalid = 1'b1;
					next_s.aw_got = 1'b0;
					next_s.w_got = 1'b0;
					next_s.wst = GPC_WR_RESP;
				end
			end
			GPC_WR_RESP: begin
				if (bready) begin
					next_s.bvalid = 1'b0;
					next_s.wst = GPC_WR_IDLE;
				end
			end
			default: next_s.wst = GPC_WR_IDLE;
		endcase
		next_s.awready = !next_s.aw_got && next_s.wst == GPC_WR_IDLE;
		next_s.wready = !next_s.w_got && next_s.wst == GPC_WR_IDLE;

		case (s.rst)
			GPC_RD_IDLE: begin
				if (s.arready && arvalid) begin
					next_s.rvalid = 1'b1;
					next_s.rdata = 32'h0;
					next_s.rresp = `GPC_RESP_SLV;
					if (sel_r[3]) begin
						next_s.rdata[7:0] = s.cfg[sel_r[2:0]] & `GPC_WMASK;
						next_s.rresp = `GPC_RESP_OKAY;
					end
					next_s.rst = GPC_RD_RESP;
				end
			end
			GPC_RD_RESP: begin
				if (rready) begin
					next_s.rvalid = 1'b0;
					next_s.rst = GPC_RD_IDLE;
				end
			end
			default: next_s.rst = GPC_RD_IDLE;
		endcase
		next_s.arready = next_s.rst == GPC_RD_IDLE;

		// Pin path; one register stage keeps every output on a flop
		for (int i = 0; i < `GPC_NPINS; i++) begin
			c = s.cfg[i];
			drv = c[`GPC_B_ALT] ? alt_drive[i] : gpio_out[i];
			drv = drv ^ c[`GPC_B_INVERT];
			next_s.pin_o[i] = drv;
			// Open drain releases the pin for a high level
			next_s.pin_oe_n[i] = c[`GPC_B_DIR_IN]
				| (c[`GPC_B_OPEN_DR] & drv);
			inb = pin_i[i] ^ c[`GPC_B_INVERT];
			next_s.gpio_in[i] = inb;
			next_s.stick[i] = c[`GPC_B_ALT] & inb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			for (int i = 0; i < `GPC_NPINS; i++)
				s.cfg[i] <= `GPC_CFG_RST;
			s.wst <= GPC_WR_IDLE;
			s.rst <= GPC_RD_IDLE;
			s.pin_oe_n <= '1;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = s.rdata;
	assign pin_o = s.pin_o;
	assign pin_oe_n = s.pin_oe_n;
	assign gpio_in = s.gpio_in;
	assign stick_one_button_one = s.stick[0];
	assign stick_one_button_two = s.stick[1];
	assign stick_two_button_one = s.stick[2];
	assign stick_two_button_two = s.stick[3];
	assign stick_one_x_axis_rc = s.stick[4];
	assign stick_one_y_axis_rc = s.stick[5];
	assign stick_two_x_axis_rc = s.stick[6];

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Pin checks on chosen pins, then reset, game port routing and read-back checks; the loop further down repeats the pin checks for all seven
	a_dir_input: assert property (s.cfg[0][0] |=> pin_oe_n[0])
		else $error("input pin is driven");
	a_dir_output: assert property (!s.cfg[1][0] && !s.cfg[1][7] |=> !pin_oe_n[1])
		else $error("push-pull output not driven");
	a_polarity_in: assert property (
		!s.cfg[2][2] |=> gpio_in[2] == ($past(pin_i[2]) ^ $past(s.cfg[2][1])))
		else $error("input polarity wrong");
	a_alt_drive: assert property (s.cfg[3][2]
		|=> pin_o[3] == ($past(alt_drive[3]) ^ $past(s.cfg[3][1])))
		else $error("alternate drive not routed");
	a_open_drain: assert property (s.cfg[4][7] |=> !(!pin_oe_n[4] && pin_o[4]))
		else $error("open drain drove high");
	a_reset_value: assert property (!$past(aresetn) |-> s.cfg == {7{`GPC_CFG_RST}})
		else $error("pin register reset value wrong");
	a_reset_pins: assert property (!$past(aresetn) |-> pin_oe_n == 7'h7F)
		else $error("pads driven right after reset");
	a_button_route: assert property (s.cfg[1][2] ##1 s.cfg[1][2]
		|-> stick_one_button_two == ($past(pin_i[1]) ^ $past(s.cfg[1][1])))
		else $error("stick one button two wrong");
	a_button_two: assert property (!s.cfg[2][2] |=> !stick_two_button_one)
		else $error("stick two button one leaks");
	a_axis_route: assert property (s.cfg[5][2]
		|=> stick_one_y_axis_rc == ($past(pin_i[5]) ^ $past(s.cfg[5][1])))
		else $error("stick one y axis wrong");
	a_axis_two: assert property (s.cfg[6][2]
		|=> stick_two_x_axis_rc == ($past(pin_i[6]) ^ $past(s.cfg[6][1])))
		else $error("stick two x axis wrong");
	a_reserved_zero: assert property (rvalid
		|-> rdata[31:8] == 24'h0 && rdata[6:3] == 4'h0)
		else $error("reserved bits read nonzero");

	////////////////////////////////////////////////////////////////////////
	// Bus side: answers must stand until taken, and a busy channel refuses
	// new requests, since only one write and one read are tracked
	a_write_resp: assert property (awvalid && awready ##0 wvalid && wready
		|-> ##[1:2] bvalid)
		else $error("write response late");
	a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rvalid_hold: assert property (rvalid && !rready
		|=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read response dropped early");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer missing");
	a_write_busy: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	a_read_busy: assert property (rvalid |-> !arready)
		else $error("read taken while response pending");
	a_unmapped_read: assert property (arvalid && arready && !sel_r[3]
		|=> rresp == `GPC_RESP_SLV && rdata == 32'h0)
		else $error("unmapped read not refused");
	// A refused write must leave every pin register as it was
	a_refused_write: assert property (s.wst == GPC_WR_IDLE && s.aw_got && s.w_got
		&& !sel_w[3] |=> s.cfg == $past(s.cfg))
		else $error("unmapped write changed a register");
	a_strobe_off: assert property (s.wst == GPC_WR_IDLE && s.aw_got && s.w_got
		&& !s.wstb |=> s.cfg == $past(s.cfg))
		else $error("write without strobe changed a register");
	a_write_lands: assert property (s.wst == GPC_WR_IDLE && s.aw_got && s.w_got
		&& sel_w[3] && s.wstb |=> s.cfg[$past(sel_w[2:0])] == ($past(s.wdata) & 8'h87))
		else $error("write did not land masked");

	////////////////////////////////////////////////////////////////////////
	// Per-pin checks; every pin has the same control layout, so one loop
	// covers them all and a slip in any single bit position shows up here
	generate
		for (genvar g = 0; g < `GPC_NPINS; g++) begin : g_pin_chk
			a_pin_input: assert property (s.cfg[g][`GPC_B_DIR_IN] |=> pin_oe_n[g])
				else $error("input pin drives its pad");
			a_pin_pushpull: assert property (!s.cfg[g][`GPC_B_DIR_IN]
				&& !s.cfg[g][`GPC_B_OPEN_DR] |=> !pin_oe_n[g])
				else $error("push-pull pin released");
			// Open drain: the enable follows the value, so a high level floats
			a_pin_od_release: assert property (!s.cfg[g][`GPC_B_DIR_IN]
				&& s.cfg[g][`GPC_B_OPEN_DR] |=> pin_oe_n[g] == pin_o[g])
				else $error("open drain enable wrong");
			a_pin_gpio_src: assert property (!s.cfg[g][`GPC_B_ALT]
				|=> pin_o[g] == ($past(gpio_out[g]) ^ $past(s.cfg[g][`GPC_B_INVERT])))
				else $error("plain pin not fed from gpio_out");
			a_pin_alt_src: assert property (s.cfg[g][`GPC_B_ALT]
				|=> pin_o[g] == ($past(alt_drive[g]) ^ $past(s.cfg[g][`GPC_B_INVERT])))
				else $error("alternate pin not fed from alt_drive");
			a_pin_alt_off: assert property (!s.cfg[g][`GPC_B_ALT] |=> !s.stick[g])
				else $error("game port signal active in plain mode");
			a_pin_stick_on: assert property (s.cfg[g][`GPC_B_ALT]
				|=> s.stick[g] == ($past(pin_i[g]) ^ $past(s.cfg[g][`GPC_B_INVERT])))
				else $error("game port signal not routed");
			a_pin_in_path: assert property (1'b1
				|=> gpio_in[g] == ($past(pin_i[g]) ^ $past(s.cfg[g][`GPC_B_INVERT])))
				else $error("input path polarity wrong");
			a_pin_cfg_rsvd: assert property (s.cfg[g][6:3] == 4'h0)
				else $error("reserved bits stored");
		end
	endgenerate

	c_write: cover property (bvalid && bready && bresp == `GPC_RESP_OKAY);
	c_read: cover property (rvalid && rready && rresp == `GPC_RESP_OKAY);
	c_unmapped: cover property (rvalid && rresp == `GPC_RESP_SLV);
	c_alt_on: cover property (s.cfg[4][2] && !pin_oe_n[4]);
	c_od_release: cover property (s.cfg[4][7] && !s.cfg[4][0] && pin_oe_n[4]);

endmodule // gpc_pin_ctrl
`default_nettype wire

//--- verilog/gpc_defs.svh
// Constants for the port 1 pin control block.
// Assumes 32-bit AXI4-Lite data and an 8-bit byte address.
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

// Register indices; byte address is four times the index
`define GPC_IDX_PIN0   6'h23
`define GPC_IDX_PIN1   6'h24
`define GPC_IDX_PIN2   6'h25
`define GPC_IDX_PIN3   6'h26
`define GPC_IDX_PIN4   6'h27
`define GPC_IDX_PIN5   6'h28
`define GPC_IDX_PIN6   6'h29
`define GPC_NPINS      7

// Field positions
`define GPC_B_DIR_IN   0
`define GPC_B_INVERT   1
`define GPC_B_ALT      2
`define GPC_B_OPEN_DR  7

`define GPC_CFG_RST    8'h01
`define GPC_WMASK      8'h87
`define GPC_RESP_OKAY  2'h0
`define GPC_RESP_SLV   2'h2

`endif

//--- verilog/gpc_pkg.sv
// Types for the port 1 pin control block.
// Assumes gpc_defs.svh for widths and positions.
`include "gpc_defs.svh"

package gpc_pkg;

	typedef enum logic [1:0] {
		GPC_WR_IDLE = 2'h1,
		GPC_WR_RESP = 2'h2
	} gpc_wr_t;

	typedef enum logic [1:0] {
		GPC_RD_IDLE = 2'h1,
		GPC_RD_RESP = 2'h2
	} gpc_rd_t;

	typedef struct packed {
		logic [`GPC_NPINS-1:0][7:0] cfg;
		gpc_wr_t                    wst;
		gpc_rd_t                    rst;
		logic                       aw_got;
		logic                       w_got;
		logic [7:0]                 waddr;
		logic [7:0]                 wdata;
		logic                       wstb;
		logic                       awready;
		logic                       wready;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [1:0]                 rresp;
		logic [31:0]                rdata;
		logic [`GPC_NPINS-1:0]      pin_o;
		logic [`GPC_NPINS-1:0]      pin_oe_n;
		logic [`GPC_NPINS-1:0]      gpio_in;
		logic [`GPC_NPINS-1:0]      stick;
	} gpc_state_t;

endpackage

//--- bench/gpc_pad_model.sv
// Board model of the seven port 1 pads, each with a pull-up.
// Assumes the module drives a pad while its enable is low.
`timescale 1ns/100ps
`default_nettype none
module gpc_pad_model (
	input  wire logic [6:0] pin_o,
	input  wire logic [6:0] pin_oe_n,
	input  wire logic [6:0] ext_drive,
	input  wire logic [6:0] ext_en,
	output logic [6:0]      pin_i
);
	// A released pad with no board driver floats high, so open drain reads back one
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			pin_i[i] = !pin_oe_n[i] ? pin_o[i] : (ext_en[i] ? ext_drive[i] : 1'b1);
		end
	end
endmodule // gpc_pad_model
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the port 1 pin control block.
// Assumes the pad model closes the loop from pin_o to pin_i.
`timescale 1ns/100ps
`default_nettype none
`include "gpc_defs.svh"
module tb_top;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0;
	logic        bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, seed = 32'h14, rd;
	logic [3:0]  wstrb = 0;
	logic [6:0]  gpio_out = 0, alt_drive = 0, ext_drive = 0, ext_en = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [6:0]  pin_i, pin_o, pin_oe_n, gpio_in;
	wire  [6:0]  stick;
	logic [7:0]  cfg [7];
	logic [7:0]  corner [5] = '{8'h00, 8'h02, 8'h06, 8'h87, 8'hFF};
	int          n_mismatch = 0, cmp_count = 0, cyc = 0, p;
	logic [31:0] rdata_w;
	gpc_pin_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata_w), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .gpio_out(gpio_out),
		.gpio_in(gpio_in), .alt_drive(alt_drive), .stick_one_button_one(stick[0]),
		.stick_one_button_two(stick[1]), .stick_two_button_one(stick[2]),
		.stick_two_button_two(stick[3]), .stick_one_x_axis_rc(stick[4]),
		.stick_one_y_axis_rc(stick[5]), .stick_two_x_axis_rc(stick[6]));
	gpc_pad_model pads (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_drive(ext_drive),
		.ext_en(ext_en), .pin_i(pin_i));
	always #4 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] addr(int i);
		return 8'(4 * (`GPC_IDX_PIN0 + i));
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw, w;
		@(posedge aclk);
		{aw, w} = 2'h3;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		{awvalid, wvalid, bready} <= 3'h7;
		while (aw | w) begin
			@(posedge aclk);
			if (aw && awready === 1'b1) begin aw = 0; awvalid <= 1'b0; end
			if (w && wready === 1'b1) begin w = 0; wvalid <= 1'b0; end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		resp = rresp;
		rd = rdata_w;
		rready <= 1'b0;
	endtask
	// Pad level worked out here too, so a wrong enable shows up in gpio_in as well
	task automatic pins();
		logic [6:0] oe, drv, pad, st;
		for (int i = 0; i < 7; i++) begin
			drv[i] = (cfg[i][2] ? alt_drive[i] : gpio_out[i]) ^ cfg[i][1];
			oe[i] = cfg[i][0] | (cfg[i][7] & drv[i]);
			pad[i] = !oe[i] ? drv[i] : (ext_en[i] ? ext_drive[i] : 1'b1);
			st[i] = cfg[i][2] & (pad[i] ^ cfg[i][1]);
		end
		check(pin_oe_n, oe);
		check(pin_o & ~oe, drv & ~oe);
		check(gpio_in, pad ^ {cfg[6][1], cfg[5][1], cfg[4][1], cfg[3][1], cfg[2][1],
			cfg[1][1], cfg[0][1]});
		check(stick, st);
	endtask
	task automatic stir();
		gpio_out <= 7'(rnd());
		alt_drive <= 7'(rnd());
		ext_drive <= 7'(rnd());
		ext_en <= 7'(rnd());
		repeat (4) @(posedge aclk);
		pins();
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			cfg[i] = 8'h01;
			rd_reg(addr(i));
			check(rd, 32'h01);
		end
		stir();
		rd_reg(8'h88);
		check(resp, 2'h2);
		wr(8'hA8, 32'h86, 4'hF);
		check(resp, 2'h2);
		wr(addr(0), 32'h86, 4'h0);
		rd_reg(addr(0));
		check(rd, 32'h01);
		$display("test reset and refusals done");
		for (int k = 0; k < 40; k++) begin
			p = int'(rnd() % 7);
			rd = rnd();
			cfg[p] = rd[7:0] & 8'h87;
			wr(addr(p), rd, 4'hF);
			rd_reg(addr(p));
			check(rd, {24'h0, cfg[p]});
			stir();
		end
		$display("test random configs done");
		foreach (corner[c]) begin
			for (int i = 0; i < 7; i++) begin
				cfg[i] = corner[c] & 8'h87;
				wr(addr(i), {24'h0, corner[c]}, 4'hF);
			end
			repeat (3) stir();
		end
		$display("test corner configs done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(addr(6));
		check(rd, 32'h01);
		$display("test second reset done");
		summarize();
	end
endmodule // tb_top
`default_nettype wire
